// ---- verilog/psda_pkg.sv ----
// Constants shared by the program space data access bridge
// Behaviour
// - Table address is table page above effective address bits 15..1, with bit 0 cleared.
// - Table page bit 7 selects user (0) or configuration (1) memory.
// - Remap address is visibility page above effective address bits 14..0.
// - Remap address top bit is forced to zero, user memory only.
// - Remap only when effective address top bit and visibility enable are set.
// - Visibility page holds 8 bits selecting one of 256 16K-word pages.
// - Data addresses from 0x8000 up map to program; low 16 bits returned.
// - Program counter advances by two per program word.
// - Word low table read returns program bits 15..0.
// - Byte low table read returns upper byte if byte select, else lower.
// - Word high table read returns bits 23..16; upper data byte zero.
// - Byte high table read returns zero when byte select is one.
// - Low table ops reach low word; high table ops reach upper byte.
// - Visibility remapping is suppressed while a table operation runs.
// - A remapped data read extends the instruction by up to two cycles.
// - Outside repeat, word and double-word moves take one extra cycle, others two.
// - In repeat, first, last, interrupt exit and re-entry take two extra.
package psda_pkg;
  localparam int EA_W = 16;
  localparam int PA_W = 24;
  localparam int PAGE_W = 8;
  localparam int DATA_W = 16;
  localparam int CC_W = 16;
  // Core control bit that opens the remap window
  localparam int VIS_EN_BIT = 2;
  // Table page bit that selects configuration space
  localparam int CFG_SEL_BIT = 7;
  // Lowest data address inside the remap window
  localparam logic [EA_W-1:0] REMAP_BASE = 16'h8000;
  localparam int REMAP_LOW_W = 15;
  localparam int BYTE_SEL_BIT = 0;
  localparam logic [PA_W-1:0] PC_STEP = 24'h000002;
  // Reset values
  localparam logic [PAGE_W-1:0] TABLE_PAGE_RST = 8'h00;
  localparam logic [PAGE_W-1:0] VIS_PAGE_RST = 8'h00;
  localparam logic [CC_W-1:0] CORE_CONTROL_RST = 16'h0000;
  localparam logic [PA_W-1:0] PC_RST = 24'h000000;
  // Extra instruction cycles for remapped reads
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_MOVE = 2'h1;
  localparam logic [1:0] EXTRA_OTHER = 2'h2;
  // Request operation codes
  localparam logic [2:0] OP_TBL_RD_LOW = 3'h0;
  localparam logic [2:0] OP_TBL_RD_HIGH = 3'h1;
  localparam logic [2:0] OP_TBL_WR_LOW = 3'h2;
  localparam logic [2:0] OP_TBL_WR_HIGH = 3'h3;
  localparam logic [2:0] OP_DATA_RD = 3'h4;
  localparam logic [2:0] OP_DATA_WR = 3'h5;
  // Program memory byte lanes
  localparam logic [2:0] BE_NONE = 3'h0;
  localparam logic [2:0] BE_LOW_BYTE = 3'h1;
  localparam logic [2:0] BE_MID_BYTE = 3'h2;
  localparam logic [2:0] BE_LOW_WORD = 3'h3;
  localparam logic [2:0] BE_HIGH_BYTE = 3'h4;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACCESS = 4'h2,
    ST_RETURN = 4'h4,
    ST_STALL = 4'h8
  } psda_state_e;
endpackage : psda_pkg

// ---- verilog/psda_addr_gen.sv ----
// Program address generation for table and remapped accesses
`timescale 1ns/1ps
module psda_addr_gen
  import psda_pkg::*;
(
  input wire logic [psda_pkg::EA_W-1:0] effective_address,
  input wire logic [psda_pkg::PAGE_W-1:0] table_page,
  input wire logic [psda_pkg::PAGE_W-1:0] visibility_page,
  input wire logic visibility_enable,
  input wire logic table_active,
  output logic [psda_pkg::PA_W-1:0] table_addr,
  output logic [psda_pkg::PA_W-1:0] remap_addr,
  output logic remap_hit,
  output logic byte_sel
);
  // Word address drops the byte select bit
  assign byte_sel = effective_address[BYTE_SEL_BIT];
  assign table_addr = {table_page, effective_address[EA_W-1:1], 1'b0};
  // Top bit held low so configuration space stays out of reach
  assign remap_addr = {1'b0, visibility_page, effective_address[REMAP_LOW_W-1:0]};
  // Window closes while a table op owns the program port
  assign remap_hit = (effective_address >= REMAP_BASE) && visibility_enable && !table_active;
endmodule : psda_addr_gen

// ---- verilog/psda_bridge.sv ----
// Program space data access bridge: table ops, remap window, stalls
`timescale 1ns/1ps
module psda_bridge
  import psda_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic table_page_load,
  input wire logic [psda_pkg::PAGE_W-1:0] table_page_value,
  input wire logic visibility_page_load,
  input wire logic [psda_pkg::PAGE_W-1:0] visibility_page_value,
  input wire logic core_control_load,
  input wire logic [psda_pkg::CC_W-1:0] core_control_value,
  input wire logic pc_load,
  input wire logic [psda_pkg::PA_W-1:0] pc_value,
  input wire logic pc_advance,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic req_byte_mode,
  input wire logic [psda_pkg::EA_W-1:0] effective_address,
  input wire logic [psda_pkg::DATA_W-1:0] req_wdata,
  input wire logic transfer_word_op,
  input wire logic transfer_double_op,
  input wire logic in_repeat,
  input wire logic repeat_first,
  input wire logic repeat_last,
  input wire logic repeat_irq_exit,
  input wire logic repeat_irq_reentry,
  input wire logic [psda_pkg::PA_W-1:0] pm_rdata,
  output logic [psda_pkg::PAGE_W-1:0] table_page_q,
  output logic [psda_pkg::PAGE_W-1:0] visibility_page_q,
  output logic [psda_pkg::CC_W-1:0] core_control_q,
  output logic [psda_pkg::PA_W-1:0] pc_q,
  output logic pm_req_q,
  output logic pm_we_q,
  output logic pm_config_q,
  output logic [psda_pkg::PA_W-1:0] pm_addr_q,
  output logic [psda_pkg::PA_W-1:0] pm_wdata_q,
  output logic [2:0] pm_byte_en_q,
  output logic ds_req_q,
  output logic ds_we_q,
  output logic [psda_pkg::EA_W-1:0] ds_addr_q,
  output logic [psda_pkg::DATA_W-1:0] ds_wdata_q,
  output logic [psda_pkg::DATA_W-1:0] rd_data_q,
  output logic rd_valid_q,
  output logic core_busy_q
);
  import psda_pkg::*;

  psda_state_e state_q, state_d;
  logic [2:0] op_q;
  logic byte_mode_q, byte_sel_q;
  logic [1:0] extra_q, cnt_q, cnt_d, extra_n;
  logic [PA_W-1:0] table_addr, remap_addr, wdata_lanes;
  logic remap_hit, byte_sel, visibility_enable, table_active, accept;
  logic req_is_table, req_is_write, remap_read, pm_go, ds_go;
  logic op_q_write, op_q_table, word_move, repeat_edge;
  logic [7:0] lo_byte, hi_byte;
  logic [DATA_W-1:0] lo_word, steer_low, steer_high, steer_data;
  logic [2:0] be_low, be_high, be_n;

  // Request decode
  assign visibility_enable = core_control_q[VIS_EN_BIT];
  assign accept = req_valid && (state_q == ST_IDLE);
  assign req_is_table = (req_op == OP_TBL_RD_LOW) || (req_op == OP_TBL_RD_HIGH)
                        || (req_op == OP_TBL_WR_LOW) || (req_op == OP_TBL_WR_HIGH);
  assign req_is_write = (req_op == OP_TBL_WR_LOW) || (req_op == OP_TBL_WR_HIGH);
  assign op_q_write = (op_q == OP_TBL_WR_LOW) || (op_q == OP_TBL_WR_HIGH);
  assign op_q_table = (op_q != OP_DATA_RD);
  // A table request, or one still running, keeps the window shut
  assign table_active = (accept && req_is_table) || ((state_q != ST_IDLE) && op_q_table);

  psda_addr_gen u_addr_gen (
    .effective_address(effective_address),
    .table_page(table_page_q),
    .visibility_page(visibility_page_q),
    .visibility_enable(visibility_enable),
    .table_active(table_active),
    .table_addr(table_addr),
    .remap_addr(remap_addr),
    .remap_hit(remap_hit),
    .byte_sel(byte_sel)
  );

  // Routing: program port for table ops and window reads, else data space
  assign remap_read = accept && (req_op == OP_DATA_RD) && remap_hit;
  assign pm_go = (accept && req_is_table) || remap_read;
  // Window is read-only, so data writes always go to data space
  assign ds_go = accept && (((req_op == OP_DATA_RD) && !remap_hit) || (req_op == OP_DATA_WR));

  // Extra cycles charged to an instruction reading through the window
  assign word_move = transfer_word_op || transfer_double_op;
  assign repeat_edge = repeat_first || repeat_last || repeat_irq_exit || repeat_irq_reentry;
  assign extra_n = in_repeat ? (repeat_edge ? EXTRA_OTHER : EXTRA_NONE)
                 : (word_move ? EXTRA_MOVE : EXTRA_OTHER);

  // Read steering; only the low program word leaves through the window
  assign lo_word = pm_rdata[DATA_W-1:0];
  assign lo_byte = byte_sel_q ? pm_rdata[15:8] : pm_rdata[7:0];
  assign hi_byte = pm_rdata[PA_W-1:DATA_W];
  assign steer_low = byte_mode_q ? {8'h00, lo_byte} : lo_word;
  // Phantom byte always reads zero
  assign steer_high = (byte_mode_q && byte_sel_q) ? 16'h0000 : {8'h00, hi_byte};
  assign steer_data = (op_q == OP_TBL_RD_HIGH) ? steer_high : (op_q == OP_TBL_RD_LOW) ? steer_low
                    : lo_word;

  // Write lanes; a byte is copied to both low lanes and the enables pick one
  assign wdata_lanes = {req_wdata[7:0], req_byte_mode ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata};
  assign be_low = !req_byte_mode ? BE_LOW_WORD : (byte_sel ? BE_MID_BYTE : BE_LOW_BYTE);
  // Writing the phantom byte does nothing
  assign be_high = (req_byte_mode && byte_sel) ? BE_NONE : BE_HIGH_BYTE;
  assign be_n = (req_op == OP_TBL_WR_HIGH) ? be_high : be_low;

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (pm_go)
          state_d = ST_ACCESS;
      end
      ST_ACCESS:
      begin
        state_d = op_q_write ? ST_IDLE : ST_RETURN;
      end
      ST_RETURN:
      begin
        cnt_d = extra_q;
        state_d = (extra_q != EXTRA_NONE) ? ST_STALL : ST_IDLE;
      end
      ST_STALL:
      begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1)
          state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
        cnt_d = 2'h0;
      end
    endcase
  end

  // State and stall counter
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      core_busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      core_busy_q <= (state_d != ST_IDLE);
    end
  end

  // Request capture for the steering stage
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_q <= OP_TBL_RD_LOW;
      byte_mode_q <= 1'b0;
      byte_sel_q <= 1'b0;
      extra_q <= EXTRA_NONE;
    end
    else if (pm_go)
    begin
      op_q <= req_op;
      byte_mode_q <= req_byte_mode;
      byte_sel_q <= byte_sel;
      extra_q <= remap_read ? extra_n : EXTRA_NONE;
    end
  end

  // Program memory port
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pm_req_q <= 1'b0;
      pm_we_q <= 1'b0;
      pm_config_q <= 1'b0;
      pm_addr_q <= '0;
      pm_wdata_q <= '0;
      pm_byte_en_q <= BE_NONE;
    end
    else
    begin
      pm_req_q <= pm_go;
      pm_we_q <= pm_go && req_is_write;
      if (pm_go)
      begin
        pm_addr_q <= req_is_table ? table_addr : remap_addr;
        pm_config_q <= req_is_table && table_page_q[CFG_SEL_BIT];
        pm_wdata_q <= wdata_lanes;
        pm_byte_en_q <= req_is_write ? be_n : BE_NONE;
      end
    end
  end

  // Data space port for accesses outside the window
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ds_req_q <= 1'b0;
      ds_we_q <= 1'b0;
      ds_addr_q <= '0;
      ds_wdata_q <= '0;
    end
    else
    begin
      ds_req_q <= ds_go;
      ds_we_q <= ds_go && (req_op == OP_DATA_WR);
      if (ds_go)
      begin
        ds_addr_q <= effective_address;
        ds_wdata_q <= req_wdata;
      end
    end
  end

  // Read return, one pulse per table read or window read
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= (state_q == ST_RETURN);
      if (state_q == ST_RETURN)
        rd_data_q <= steer_data;
    end
  end

  // Page and control registers written by the core
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      table_page_q <= TABLE_PAGE_RST;
      visibility_page_q <= VIS_PAGE_RST;
      core_control_q <= CORE_CONTROL_RST;
    end
    else
    begin
      if (table_page_load)
        table_page_q <= table_page_value;
      if (visibility_page_load)
        visibility_page_q <= visibility_page_value;
      if (core_control_load)
        core_control_q <= core_control_value;
    end
  end

  // Program counter counts in steps of two, bit 0 always clear
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pc_q <= PC_RST;
    else if (pc_load)
      pc_q <= {pc_value[PA_W-1:1], 1'b0};
    else if (pc_advance)
      pc_q <= pc_q + PC_STEP;
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_remap_move;
    remap_read && !in_repeat && word_move;
  endsequence
  sequence s_remap_other;
    remap_read && (in_repeat ? repeat_edge : !word_move);
  endsequence
  sequence s_remap_fast;
    remap_read && in_repeat && !repeat_edge;
  endsequence

  a_table_addr_form: assert property (pm_go && req_is_table |=> pm_addr_q == $past(table_addr))
    else $error("table address not page over effective address");
  a_config_select: assert property (pm_go && req_is_table |=> pm_config_q == pm_addr_q[PA_W-1])
    else $error("configuration select disagrees with page bit");
  a_remap_addr: assert property (remap_read |=> pm_addr_q[22:15] == $past(visibility_page_q))
    else $error("remap address not built from visibility page");
  a_remap_user: assert property (pm_req_q && !op_q_table |-> !pm_addr_q[PA_W-1] && !pm_config_q)
    else $error("remap reached configuration space");
  a_window_route: assert property (accept && req_op == OP_DATA_RD |=>
      pm_req_q == ($past(effective_address[EA_W-1]) && $past(visibility_enable)))
    else $error("data read routed wrongly");
  a_pc_step: assert property (pc_advance && !pc_load |=> pc_q == $past(pc_q) + PC_STEP)
    else $error("program counter did not advance by two");
  a_low_word: assert property (state_q == ST_RETURN && op_q == OP_TBL_RD_LOW && !byte_mode_q |=>
      rd_valid_q && rd_data_q == $past(pm_rdata[15:0]))
    else $error("low word read wrong");
  a_low_byte: assert property (state_q == ST_RETURN && op_q == OP_TBL_RD_LOW && byte_mode_q |=>
      rd_data_q == {8'h00, $past(byte_sel_q) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])})
    else $error("low byte read wrong");
  a_high_phantom: assert property (rd_valid_q && $past(op_q) == OP_TBL_RD_HIGH |-> rd_data_q[15:8] == 8'h00)
    else $error("phantom byte not zero");
  a_high_byte_zero: assert property (state_q == ST_RETURN && op_q == OP_TBL_RD_HIGH && byte_mode_q
      && byte_sel_q |=> rd_data_q == 16'h0000)
    else $error("phantom byte read not zero");
  a_write_lanes: assert property (pm_we_q |-> (op_q == OP_TBL_WR_HIGH) ? pm_byte_en_q[1:0] == 2'h0
      : !pm_byte_en_q[2])
    else $error("table write touched wrong lanes");
  a_table_no_remap: assert property (state_q != ST_IDLE && op_q_table |-> !remap_hit)
    else $error("remap open during table op");
  a_stall_move: assert property (s_remap_move |=> core_busy_q [*3] ##1 !core_busy_q)
    else $error("word move stall not one extra cycle");
  a_stall_other: assert property (s_remap_other |=> core_busy_q [*4] ##1 !core_busy_q)
    else $error("stall not two extra cycles");
  a_stall_repeat: assert property (s_remap_fast |=> core_busy_q [*2] ##1 !core_busy_q)
    else $error("repeat middle iteration stalled");
  a_byte_select: assert property (pm_go |=> byte_sel_q == $past(effective_address[BYTE_SEL_BIT]))
    else $error("byte select not effective address bit 0");
endmodule : psda_bridge

// ---- testbench/psda_pm_model.sv ----
// Program memory model standing behind the bridge's program port
`timescale 1ns/1ps
module psda_pm_model
  import psda_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pm_req_q,
  input wire logic pm_we_q,
  input wire logic [psda_pkg::PA_W-1:0] pm_addr_q,
  input wire logic [psda_pkg::PA_W-1:0] pm_wdata_q,
  input wire logic [2:0] pm_byte_en_q,
  output logic [psda_pkg::PA_W-1:0] pm_rdata
);
  logic [PA_W-1:0] mem [logic [PA_W-1:0]];
  logic [PA_W-1:0] word_v;

  // Preset constants keep the upper byte all ones or all zeros
  function automatic logic [PA_W-1:0] preset(input logic [PA_W-1:0] a);
    return {(a[1] ? 8'h00 : 8'hFF), a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h3C96};
  endfunction : preset

  // Data valid only the cycle after a read; otherwise it toggles so stale use shows
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pm_rdata <= 24'h000000;
    else if (pm_req_q && !pm_we_q)
      pm_rdata <= mem.exists(pm_addr_q) ? mem[pm_addr_q] : preset(pm_addr_q);
    else
      pm_rdata <= ~pm_rdata;
  end

  // Lane-wise writes; a lane with its enable low keeps its old byte
  always @(posedge clock)
  begin
    if (reset_n && pm_req_q && pm_we_q)
    begin
      word_v = mem.exists(pm_addr_q) ? mem[pm_addr_q] : preset(pm_addr_q);
      for (int i = 0; i < 3; i++)
        if (pm_byte_en_q[i]) word_v[8*i +: 8] = pm_wdata_q[8*i +: 8];
      mem[pm_addr_q] = word_v;
    end
  end
endmodule : psda_pm_model

// ---- testbench/psda_bridge_tb_top.sv ----
// Self-checking bench for the program space data access bridge
`timescale 1ns/1ps
module psda_bridge_tb_top;
  import psda_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic table_page_load, visibility_page_load, core_control_load, pc_load, pc_advance, req_valid, req_byte_mode;
  logic transfer_word_op, transfer_double_op, in_repeat, repeat_first, repeat_last;
  logic repeat_irq_exit, repeat_irq_reentry, pm_req_q, pm_we_q, pm_config_q, ds_req_q, ds_we_q;
  logic rd_valid_q, core_busy_q;
  logic [7:0] table_page_value, visibility_page_value, table_page_q, visibility_page_q;
  logic [15:0] core_control_value, core_control_q, effective_address, req_wdata, ds_addr_q, ds_wdata_q, rd_data_q;
  logic [23:0] pc_value, pc_q, pm_rdata, pm_addr_q, pm_wdata_q;
  logic [2:0] req_op, pm_byte_en_q;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_busy, pm_at, rd_at, ds_at, we_at;
  logic [6:0] ctx_tab [8] = '{7'h40, 7'h20, 7'h00, 7'h10, 7'h18, 7'h14, 7'h12, 7'h11};
  int busy_tab [8] = '{3, 3, 4, 2, 4, 4, 4, 4};
  logic [23:0] a;

  psda_bridge psda_bridge_inst (.clock, .reset_n, .table_page_load, .table_page_value, .visibility_page_load,
    .visibility_page_value, .core_control_load, .core_control_value, .pc_load, .pc_value, .pc_advance,
    .req_valid, .req_op, .req_byte_mode, .effective_address, .req_wdata, .transfer_word_op,
    .transfer_double_op, .in_repeat, .repeat_first, .repeat_last, .repeat_irq_exit, .repeat_irq_reentry,
    .pm_rdata, .table_page_q, .visibility_page_q, .core_control_q, .pc_q, .pm_req_q, .pm_we_q, .pm_config_q,
    .pm_addr_q, .pm_wdata_q, .pm_byte_en_q, .ds_req_q, .ds_we_q, .ds_addr_q, .ds_wdata_q, .rd_data_q,
    .rd_valid_q, .core_busy_q);

  psda_pm_model psda_pm_model_inst (.clock, .reset_n, .pm_req_q, .pm_we_q, .pm_addr_q, .pm_wdata_q,
    .pm_byte_en_q, .pm_rdata);

  // 100 MHz clock
  always #5 clock = ~clock;

  // Hang guard: a few hundred cycles of traffic, generous margin
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  // Same preset contents as the program memory model
  function automatic logic [23:0] pm_word(input logic [23:0] x);
    return {(x[1] ? 8'h00 : 8'hFF), x[15:0] ^ {x[23:16], x[23:16]} ^ 16'h3C96};
  endfunction : pm_word

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic set_regs(input logic [7:0] tp, input logic [7:0] vp, input logic [15:0] cc);
    @(negedge clock);
    {table_page_load, visibility_page_load, core_control_load} = 3'h7;
    {table_page_value, visibility_page_value, core_control_value} = {tp, vp, cc};
    @(negedge clock);
    {table_page_load, visibility_page_load, core_control_load} = 3'h0;
  endtask : set_regs

  // One request cycle, then eight cycles of watching pulses and stalls
  task automatic do_req(input logic [2:0] op, input logic bm, input logic [15:0] ea, input logic [15:0] wd,
                        input logic [6:0] ctx);
    @(negedge clock);
    {req_valid, req_op, req_byte_mode, effective_address, req_wdata} = {1'b1, op, bm, ea, wd};
    {transfer_word_op, transfer_double_op, in_repeat, repeat_first, repeat_last, repeat_irq_exit,
      repeat_irq_reentry} = ctx;
    n_busy = 0;
    pm_at = 0;
    rd_at = 0;
    ds_at = 0;
    we_at = 0;
    for (int k = 1; k <= 8; k++)
    begin
      @(negedge clock);
      req_valid = 1'b0;
      if (core_busy_q === 1'b1) n_busy++;
      if (pm_req_q === 1'b1) pm_at = k;
      if (rd_valid_q === 1'b1) rd_at = k;
      if (ds_req_q === 1'b1) ds_at = k;
      if (ds_we_q === 1'b1) we_at = k;
    end
  endtask : do_req

  task automatic rd_case(input logic [2:0] op, input logic bm, input logic [15:0] ea, input logic [6:0] ctx,
                         input logic [23:0] addr, input logic [23:0] w, input int busy);
    logic [15:0] mask;
    logic [15:0] exp_v;
    mask = bm ? 16'h00FF : 16'hFFFF;
    exp_v = (op == OP_TBL_RD_HIGH) ? ((bm && ea[0]) ? 16'h0000 : {8'h00, w[23:16]}) :
      ((bm && ea[0]) ? {8'h00, w[15:8]} : w[15:0]);
    do_req(op, bm, ea, 16'h0000, ctx);
    check(32'(pm_at), 32'h1, "program request cycle");
    check(32'(pm_addr_q), 32'(addr), "program address");
    check(32'(rd_at), 32'h3, "read valid cycle");
    check(32'(rd_data_q & mask), 32'(exp_v & mask), "read data");
    check(32'(n_busy), 32'(busy), "stall cycles");
  endtask : rd_case

  task automatic wr_case(input logic [2:0] op, input logic bm, input logic [15:0] ea, input logic [15:0] wd);
    do_req(op, bm, ea, wd, 7'h00);
    check(32'(pm_at), 32'h1, "program write cycle");
    check(32'(n_busy), 32'h1, "write stall");
    check(32'(rd_at), 32'h0, "no read return for write");
  endtask : wr_case

  task automatic ds_case(input logic [2:0] op, input logic [15:0] ea);
    do_req(op, 1'b0, ea, 16'h5A5A, 7'h40);
    check(32'(pm_at), 32'h0, "no program access");
    check(32'(ds_at), 32'h1, "data request cycle");
    check(32'(ds_addr_q), 32'(ea), "data address");
    check(32'(we_at), (op == OP_DATA_WR) ? 32'h1 : 32'h0, "data write strobe");
    check(32'(ds_wdata_q), 32'h5A5A, "data write value");
  endtask : ds_case

  // Main sequence
  initial
  begin
    {table_page_load, visibility_page_load, core_control_load, pc_load, pc_advance, req_valid} = 6'h00;
    {table_page_value, visibility_page_value, core_control_value, pc_value} = 56'h0;
    {req_op, req_byte_mode, effective_address, req_wdata} = 36'h0;
    {transfer_word_op, transfer_double_op, in_repeat, repeat_first, repeat_last} = 5'h00;
    {repeat_irq_exit, repeat_irq_reentry} = 2'h0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    check(32'(table_page_q), 32'h0, "table page reset");
    check(32'(visibility_page_q), 32'h0, "visibility page reset");
    check(32'(core_control_q), 32'h0, "core control reset");
    // Odd load lands word aligned, then three steps of two
    pc_value = 24'h000123;
    pc_load = 1'b1;
    @(negedge clock);
    pc_load = 1'b0;
    pc_advance = 1'b1;
    repeat (3) @(negedge clock);
    pc_advance = 1'b0;
    check(32'(pc_q), 32'h000128, "program counter");
    // Table reads with the window open: the window must stay out of the way
    set_regs(8'h12, 8'hC3, 16'h0004);
    a = 24'h123454;
    rd_case(OP_TBL_RD_LOW, 1'b0, 16'h3454, 7'h00, a, pm_word(a), 2);
    check(32'(pm_config_q), 32'h0, "user space");
    rd_case(OP_TBL_RD_LOW, 1'b1, 16'h3455, 7'h00, a, pm_word(a), 2);
    rd_case(OP_TBL_RD_LOW, 1'b1, 16'h3454, 7'h00, a, pm_word(a), 2);
    rd_case(OP_TBL_RD_HIGH, 1'b0, 16'h3454, 7'h00, a, pm_word(a), 2);
    rd_case(OP_TBL_RD_HIGH, 1'b1, 16'h3454, 7'h00, a, pm_word(a), 2);
    rd_case(OP_TBL_RD_HIGH, 1'b1, 16'h3455, 7'h00, a, pm_word(a), 2);
    rd_case(OP_TBL_RD_LOW, 1'b0, 16'hB000, 7'h00, 24'h12B000, pm_word(24'h12B000), 2);
    // Low and high halves written separately; a phantom byte write changes nothing
    wr_case(OP_TBL_WR_LOW, 1'b0, 16'h2000, 16'hBEEF);
    wr_case(OP_TBL_WR_HIGH, 1'b0, 16'h2000, 16'h0077);
    wr_case(OP_TBL_WR_HIGH, 1'b1, 16'h2001, 16'h0033);
    rd_case(OP_TBL_RD_LOW, 1'b0, 16'h2000, 7'h00, 24'h122000, 24'h77BEEF, 2);
    rd_case(OP_TBL_RD_HIGH, 1'b0, 16'h2000, 7'h00, 24'h122000, 24'h77BEEF, 2);
    // Byte writes land in a single lane each
    wr_case(OP_TBL_WR_LOW, 1'b1, 16'h2001, 16'h00A5);
    wr_case(OP_TBL_WR_LOW, 1'b1, 16'h2000, 16'h005C);
    wr_case(OP_TBL_WR_HIGH, 1'b1, 16'h2000, 16'h0066);
    rd_case(OP_TBL_RD_LOW, 1'b0, 16'h2000, 7'h00, 24'h122000, 24'h66A55C, 2);
    rd_case(OP_TBL_RD_HIGH, 1'b0, 16'h2000, 7'h00, 24'h122000, 24'h66A55C, 2);
    set_regs(8'h85, 8'hC3, 16'h0004);
    rd_case(OP_TBL_RD_LOW, 1'b0, 16'h0010, 7'h00, 24'h850010, pm_word(24'h850010), 2);
    check(32'(pm_config_q), 32'h1, "configuration space");
    // Window reads: address build and stall length per instruction kind
    a = {1'b0, 8'hC3, 15'h1ABC};
    rd_case(OP_DATA_RD, 1'b0, 16'h9ABC, 7'h40, a, pm_word(a), 3);
    set_regs(8'h85, 8'hFF, 16'h0004);
    for (int i = 0; i < 8; i++)
    begin
      a = {1'b0, 8'hFF, 15'(i * 2)};
      rd_case(OP_DATA_RD, 1'b0, 16'(16'h8000 + i * 2), ctx_tab[i], a, pm_word(a), busy_tab[i]);
    end
    check(32'(pm_config_q), 32'h0, "window stays in user space");
    // Data-space routes: below the window, window closed, write into window
    ds_case(OP_DATA_RD, 16'h7FFE);
    ds_case(OP_DATA_WR, 16'hC000);
    set_regs(8'h85, 8'hFF, 16'hFFFB);
    ds_case(OP_DATA_RD, 16'h9ABC);
    end_of_test();
  end
endmodule : psda_bridge_tb_top
